/* dee_dev.sv */
// Data EEPROM controller: control, key unlock, address capture, array cycles
// Assumes the core side keeps to the unlock and busy-read rules
//
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module dee_dev
  import dee_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset
  input wire logic pin_or_wdt_rst, // Pin or watchdog reset, sync
  dee_if.dev bus, // Core side
  output logic [15:0] ctrl_out // Control register view
);
  import dee_pkg::*;
  typedef enum logic [1:0] {
    DEE_IDLE = 2'b00,
    DEE_RUN = 2'b01,
    DEE_APPLY = 2'b10
  } dee_state_t;

  // ***************************************
  // Request decode
  // ***************************************
  logic [15:0] ctrl_q, ctrl_d;
  logic [1:0] key_q;
  logic [ADDR_W-1:0] tgt_q;
  logic [DATA_W-1:0] latch_q;
  logic [DATA_W-1:0] rdata_q;
  logic ack_q, rd_pend_q, done_q;
  dee_state_t st_q;
  logic [CNT_W-1:0] cnt_q;
  logic [3:0] left_q;
  logic [IDX_W-1:0] idx_q;
  wire take = bus.req && !ack_q;
  wire ctrl_wr = take && bus.op == DEE_OP_CTRL_WR;
  wire key_wr = take && bus.op == DEE_OP_KEY_WR;
  wire tbl_wr = take && bus.op == DEE_OP_TBL_WR;
  wire any_rd = take && (bus.op == DEE_OP_TBL_RD || bus.op == DEE_OP_PSV_RD);
  wire unlocked = key_q == 2'd2;
  wire start_req = ctrl_wr && bus.wdata[START_BIT] && unlocked
    && bus.wdata[ENABLE_BIT] && st_q == DEE_IDLE;
  wire [5:0] op_sel = ctrl_q[5:0];
  wire is_erase = ctrl_q[ERASE_BIT];
  wire op_bulk = is_erase && op_sel[5:2] == OP_BULK_HI;
  wire op_e8 = is_erase && op_sel == OP_ERASE8;
  wire op_e4 = is_erase && op_sel == OP_ERASE4;
  wire op_e1 = is_erase && op_sel == OP_ERASE1;
  wire op_wr = !is_erase && op_sel[5:2] == OP_WRITE_HI;
  // Partial size from low two bits; word index drops the byte bit
  wire [3:0] part_words = op_e8 ? 4'd8 : (op_e4 ? 4'd4 : 4'd1);
  wire [IDX_W-1:0] tgt_idx = tgt_q[IDX_W:1];
  wire [IDX_W-1:0] base_idx = op_e8 ? {tgt_idx[IDX_W-1:3], 3'b000}
    : (op_e4 ? {tgt_idx[IDX_W-1:2], 2'b00} : tgt_idx);
  wire valid_op = op_bulk || op_e8 || op_e4 || op_e1 || op_wr;
  wire apply = st_q == DEE_APPLY;
  wire arr_we = apply;
  wire [DATA_W-1:0] arr_wd = op_wr ? latch_q : ERASED_WORD;
  wire last_word = op_bulk ? idx_q == IDX_W'(DEPTH - 1) : left_q == 4'd1;
  logic [DATA_W-1:0] arr_rd;

  dee_array u_arr (
    .clk(clk),
    .rd_en(any_rd),
    .rd_idx(bus.addr[IDX_W:1]),
    .rd_data(arr_rd),
    .wr_en(arr_we),
    .wr_idx(idx_q),
    .wr_data(arr_wd)
  );

  // ***************************************
  // Control register next value
  // ***************************************
  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrl_wr) begin
      ctrl_d = (ctrl_q & ~CTRL_WMASK) | (bus.wdata & CTRL_WMASK);
      ctrl_d[START_BIT] = ctrl_q[START_BIT] | start_req;
      ctrl_d[ERROR_BIT] = bus.wdata[ERROR_BIT];
    end
    if (apply && last_word) begin
      ctrl_d[START_BIT] = 1'b0;
      ctrl_d[ENABLE_BIT] = 1'b0;
    end
    if (pin_or_wdt_rst && st_q != DEE_IDLE) begin
      ctrl_d[ERROR_BIT] = 1'b1;
      ctrl_d[START_BIT] = 1'b0;
    end
  end

  // ***************************************
  // Registers
  // ***************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
      key_q <= 2'd0;
      tgt_q <= '0;
      latch_q <= '0;
      ack_q <= 1'b0;
      rd_pend_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      ack_q <= take;
      rd_pend_q <= any_rd;
      done_q <= apply && last_word;
      // Key window lasts for the next access only
      if (key_wr && bus.wdata[7:0] == KEY_FIRST) begin
        key_q <= 2'd1;
      end else if (key_wr && key_q == 2'd1 && bus.wdata[7:0] == KEY_SECOND) begin
        key_q <= 2'd2;
      end else if (take) begin
        key_q <= 2'd0;
      end
      if (tbl_wr) begin
        tgt_q <= bus.addr;
        latch_q <= bus.wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (ctrl_wr || take) begin
      rdata_q <= ctrl_q;
    end else if (rd_pend_q) begin
      rdata_q <= arr_rd;
    end
  end

  // ***************************************
  // Cycle sequencer
  // ***************************************
  always_ff @(posedge clk) begin
    if (!rst_n || pin_or_wdt_rst) begin
      st_q <= DEE_IDLE;
      cnt_q <= '0;
      left_q <= '0;
      idx_q <= '0;
    end else begin
      unique case (st_q)
        DEE_IDLE: begin
          if (start_req) begin
            st_q <= DEE_RUN;
            cnt_q <= CNT_W'(CYCLE_CLKS - 1);
            left_q <= part_words;
            idx_q <= op_bulk ? '0 : base_idx;
          end
        end
        DEE_RUN: begin
          if (!valid_op) begin
            st_q <= DEE_IDLE;
          end else if (cnt_q == '0) begin
            st_q <= DEE_APPLY;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        DEE_APPLY: begin
          if (last_word) begin
            st_q <= DEE_IDLE;
          end else begin
            st_q <= DEE_APPLY;
            idx_q <= idx_q + IDX_W'(1);
            left_q <= left_q - 4'd1;
          end
        end
        default: st_q <= DEE_IDLE;
      endcase
    end
  end

  assign bus.ack = ack_q;
  assign bus.rdata = rdata_q;
  assign bus.done_pulse = done_q;
  assign bus.busy = ctrl_q[START_BIT];
  assign ctrl_out = ctrl_q;
endmodule // dee_dev

/* dee_pkg.sv */
// Constants and types shared by the data EEPROM controller and the core-side driver
// Assumes one clock domain, synchronous active-low reset
package dee_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 24;
  localparam int DEPTH = 256;
  localparam int IDX_W = 8;
  // Control register fields
  localparam int START_BIT = 15;
  localparam int ENABLE_BIT = 14;
  localparam int ERROR_BIT = 13;
  localparam int PGM_ONLY_BIT = 12;
  localparam int ERASE_BIT = 6;
  localparam logic [15:0] CTRL_WMASK = 16'h507f;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [5:0] OP_ERASE8 = 6'h1a;
  localparam logic [5:0] OP_ERASE4 = 6'h19;
  localparam logic [5:0] OP_ERASE1 = 6'h18;
  localparam logic [3:0] OP_BULK_HI = 4'h4;
  localparam logic [3:0] OP_WRITE_HI = 4'h1;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  // Cycle time of one array operation
  localparam int CYCLE_NS = 4000;
  localparam int CLK_NS = 8;
  localparam int CYCLE_CLKS = CYCLE_NS / CLK_NS;
  localparam int CNT_W = 10;
  // Register indices on the core side (Avalon word addresses)
  localparam logic [1:0] REG_CMD = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_IRQ_MASK = 2'h2;
  localparam logic [1:0] REG_RDATA = 2'h3;
  typedef enum logic [2:0] {
    DEE_OP_CTRL_WR = 3'b000,
    DEE_OP_CTRL_RD = 3'b001,
    DEE_OP_KEY_WR = 3'b010,
    DEE_OP_TBL_WR = 3'b011,
    DEE_OP_TBL_RD = 3'b100,
    DEE_OP_PSV_RD = 3'b101
  } dee_op_t;
endpackage

/* dee_if.sv */
// Core-to-controller access channel
// Assumes both ends on the same clock
`timescale 1ns/10ps
interface dee_if;
  import dee_pkg::*;
  logic req;
  dee_op_t op;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic ack;
  logic [DATA_W-1:0] rdata;
  logic done_pulse;
  logic busy;
  modport dev (input req, op, addr, wdata, output ack, rdata, done_pulse, busy);
  modport core (output req, op, addr, wdata, input ack, rdata, done_pulse, busy);
endinterface

/* dee_array.sv */
// 256 x 16 data EEPROM storage with one registered read port and one write port
// Assumes the controller issues one operation per cycle
`timescale 1ns/10ps
module dee_array
  import dee_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rd_en, // Read strobe
  input wire logic [IDX_W-1:0] rd_idx, // Read word index
  output logic [DATA_W-1:0] rd_data, // Registered read word
  input wire logic wr_en, // Write strobe
  input wire logic [IDX_W-1:0] wr_idx, // Write word index
  input wire logic [DATA_W-1:0] wr_data // Write word
);
  import dee_pkg::*;
  logic [DATA_W-1:0] mem [DEPTH];
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_idx];
    end
  end
endmodule // dee_array

/* dee_core.sv */
// Core-side driver: Avalon-MM slave that sequences table and key accesses
// Assumes the controller answers each request with a one-cycle ack
`timescale 1ns/10ps
module dee_core
  import dee_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset
  input wire logic [1:0] avs_address, // Word address
  input wire logic avs_read, // Read strobe
  input wire logic avs_write, // Write strobe
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  output logic irq, // Level interrupt
  dee_if.core bus // Controller side
);
  import dee_pkg::*;
  // Command word: op in [26:24], address in [23:0]; write data comes from the data register
  logic [DATA_W-1:0] wdat_q, rdat_q;
  logic [ADDR_W-1:0] addr_q;
  logic [2:0] op_q;
  logic req_q, busy_q;
  logic [1:0] sts_q, mask_q;
  logic [31:0] rd_q;
  logic rvalid_q;
  logic ack_dly_q;
  wire cmd_wr = avs_write && avs_address == REG_CMD && !req_q;
  wire dat_wr = avs_write && avs_address == REG_RDATA;
  wire sts_wr = avs_write && avs_address == REG_STATUS;
  wire msk_wr = avs_write && avs_address == REG_IRQ_MASK;
  // Commands stall while one is in flight; reads answer one cycle late
  assign avs_waitrequest = (avs_write && avs_address == REG_CMD && req_q) || (avs_read && !rvalid_q);
  wire [31:0] rd_mux = avs_address == REG_STATUS ? {29'h0, bus.busy, sts_q}
    : (avs_address == REG_IRQ_MASK ? {30'h0, mask_q}
    : (avs_address == REG_RDATA ? {16'h0, rdat_q} : {5'h0, op_q, addr_q}));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_q <= 1'b0;
      op_q <= '0;
      addr_q <= '0;
      wdat_q <= '0;
      rdat_q <= '0;
      sts_q <= '0;
      mask_q <= '0;
      rd_q <= '0;
      rvalid_q <= 1'b0;
      busy_q <= 1'b0;
      ack_dly_q <= 1'b0;
    end else begin
      ack_dly_q <= bus.ack;
      rvalid_q <= avs_read && !rvalid_q;
      rd_q <= rd_mux;
      busy_q <= bus.busy;
      if (cmd_wr) begin
        req_q <= 1'b1;
        op_q <= avs_writedata[26:24];
        addr_q <= avs_writedata[23:0];
      end else if (bus.ack) begin
        req_q <= 1'b0;
      end
      if (dat_wr) begin
        wdat_q <= avs_writedata[15:0];
      end
      // Array words arrive one cycle after ack; control reads still stand then
      if (ack_dly_q) begin
        rdat_q <= bus.rdata;
      end
      if (msk_wr) begin
        mask_q <= avs_writedata[1:0];
      end
      // Bit 0 done, bit 1 busy fell; set wins over clear
      sts_q[0] <= bus.done_pulse | (sts_q[0] & ~(sts_wr & avs_writedata[0]));
      sts_q[1] <= (busy_q & ~bus.busy) | (sts_q[1] & ~(sts_wr & avs_writedata[1]));
    end
  end

  assign bus.req = req_q;
  assign bus.op = dee_op_t'(op_q);
  assign bus.addr = addr_q;
  assign bus.wdata = wdat_q;
  assign avs_readdata = rd_q;
  assign irq = |(sts_q & mask_q);
endmodule // dee_core

/* dee_properties.sv */
// Checker on the core-to-controller channel
// Assumes the dee_if signals as inputs, one clock
`timescale 1ns/10ps
module dee_properties
  import dee_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst_n, // Sync reset
  input wire logic req, // Request
  input dee_op_t op, // Operation
  input wire logic [ADDR_W-1:0] addr, // Address
  input wire logic [DATA_W-1:0] wdata, // Write data
  input wire logic ack, // Answer
  input wire logic done_pulse, // Cycle done
  input wire logic busy // Cycle running
);
  // Bulk erase adds one apply cycle per word
  localparam int LIM = CYCLE_CLKS + DEPTH + 8;
  logic [18:0] h0_q, h1_q, h2_q, c0, c1, c2;
  logic [CNT_W-1:0] len_q;
  logic busy_q;
  // Last three answered requests
  assign c0 = ack ? {op, wdata} : h0_q;
  assign c1 = ack ? h0_q : h1_q;
  assign c2 = ack ? h1_q : h2_q;
  always_ff @(posedge clk) begin
    if (ack) begin
      h0_q <= {op, wdata};
      h1_q <= h0_q;
      h2_q <= h1_q;
    end
    busy_q <= busy;
    len_q <= (busy && !busy_q) ? 10'h1 : (busy ? len_q + 10'h1 : len_q);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_key_gate: assert property ($rose(busy) |-> c2[18:16] == DEE_OP_KEY_WR && c2[7:0] == KEY_FIRST
    && c1[18:16] == DEE_OP_KEY_WR && c1[7:0] == KEY_SECOND && c0[18:16] == DEE_OP_CTRL_WR
    && c0[START_BIT] && c0[ENABLE_BIT]) else $error("start without unlock");
  a_busy_bound: assert property ($rose(busy) |-> ##[1:LIM] !busy) else $error("cycle too long");
  a_done_full: assert property (done_pulse |-> !busy && len_q >= CYCLE_CLKS) else $error("done early");
  a_done_fall: assert property (done_pulse |-> $past(busy) || $past(busy, 2)) else $error("done stray");
  a_ack_pulse: assert property (ack |=> !ack) else $error("ack too long");
  a_ack_cause: assert property (ack |-> $past(req)) else $error("ack without req");
  a_req_hold: assert property (req && !ack |=> req && $stable(op) && $stable(addr)
    && $stable(wdata)) else $error("request changed");
  a_no_busy_read: assert property (busy && req |-> op != DEE_OP_TBL_RD) else $error("read while busy");
endmodule // dee_properties

/* tb_top.sv */
// Bench: bus accesses through dee_core to dee_dev
// Assumes the two ends joined by one dee_if
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
  import dee_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic abort = 1'b0;
  logic [1:0] adr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = '0;
  logic [31:0] rdat, d;
  logic wait_r, irq;
  logic [15:0] ctrl;
  int fail_count = 0;
  int n_checks = 0;
  logic [5:0] ops [4] = '{OP_ERASE1, OP_ERASE4, OP_ERASE8, {OP_BULK_HI, 2'b00}};
  int idx [4] = '{8, 4, 0, -1};
  logic [7:0] gone [4] = '{8'h8, 8'h7, 8'h3, 8'h9};
  logic [7:0] kept [4] = '{8'h7, 8'h3, 8'h9, 8'h0};
  dee_if ifc ();
  dee_core dee_core_i (.clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wait_r), .irq(irq), .bus(ifc.core));
  dee_dev dee_dev_i (.clk(clk), .rst_n(rst_n), .pin_or_wdt_rst(abort), .bus(ifc.dev), .ctrl_out(ctrl));
  dee_properties dee_properties_i (.clk(clk), .rst_n(rst_n), .req(ifc.req), .op(ifc.op), .addr(ifc.addr),
    .wdata(ifc.wdata), .ack(ifc.ack), .done_pulse(ifc.done_pulse), .busy(ifc.busy));
  always #4 clk = ~clk;
  // ****************
  // Access tasks
  // ****************
  task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] v);
    int n;
    n = 0;
    adr <= a;
    wd <= v;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wait_r !== 1'b0 && n < 100);
    d = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic cmd(input dee_op_t o, input logic [23:0] a, input logic [15:0] v);
    bus(1'b1, REG_RDATA, {16'h0, v});
    bus(1'b1, REG_CMD, {5'h0, o, a});
    do @(posedge clk); while (ifc.ack !== 1'b1);
    repeat (2) @(posedge clk);
  endtask
  task automatic rd_word(input dee_op_t o, input logic [7:0] i, input logic [15:0] e);
    cmd(o, {15'h0, i, 1'b0}, 16'h0);
    bus(1'b0, REG_RDATA, '0);
    `CHK(d[15:0], e)
  endtask
  task automatic run(input logic [15:0] c, input int i, input logic [15:0] v);
    if (!c[ERASE_BIT] && i >= 0) cmd(DEE_OP_TBL_WR, 24'(i * 2), v);
    cmd(DEE_OP_CTRL_WR, 24'h0, c);
    if (c[ERASE_BIT] && i >= 0) cmd(DEE_OP_TBL_WR, 24'(i * 2), v);
    cmd(DEE_OP_KEY_WR, 24'h0, {8'h0, KEY_FIRST});
    cmd(DEE_OP_KEY_WR, 24'h0, {8'h0, KEY_SECOND});
    cmd(DEE_OP_CTRL_WR, 24'h0, c | 16'h8000);
  endtask
  task automatic wait_done(input logic m);
    int n;
    n = 0;
    do begin
      bus(1'b0, REG_STATUS, '0);
      n++;
    end while (d[0] !== 1'b1 && n < 2000);
    `CHK(d[0], 1'b1)
    `CHK(ctrl[START_BIT], 1'b0)
    `CHK(irq, m)
    bus(1'b1, REG_STATUS, 32'h3);
    `CHK(irq, 1'b0)
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ****************
  // Tests
  // ****************
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK(ctrl, CTRL_RST)
    for (int i = 0; i < 10; i++) begin
      run(16'h4004, i, 16'h1000 + 16'(i));
      wait_done(1'b0);
    end
    for (int i = 0; i < 10; i++) begin
      rd_word(DEE_OP_TBL_RD, 8'(i), 16'h1000 + 16'(i));
    end
    rd_word(DEE_OP_PSV_RD, 8'h9, 16'h1009);
    for (int k = 0; k < 3; k++) begin
      if (k > 0) cmd(DEE_OP_KEY_WR, 24'h0, k == 1 ? 16'haa : 16'h55);
      if (k > 0) cmd(DEE_OP_KEY_WR, 24'h0, k == 1 ? 16'h55 : 16'haa);
      cmd(DEE_OP_CTRL_WR, 24'h0, k == 2 ? 16'h8004 : 16'hc004);
      `CHK(ctrl[START_BIT], 1'b0)
    end
    bus(1'b1, REG_IRQ_MASK, 32'h1);
    for (int k = 0; k < 4; k++) begin
      run(16'h4040 | {10'h0, ops[k]}, idx[k], 16'h0);
      wait_done(1'b1);
      rd_word(DEE_OP_TBL_RD, gone[k], ERASED_WORD);
      rd_word(DEE_OP_TBL_RD, kept[k], k == 3 ? ERASED_WORD : 16'h1000 + 16'(kept[k]));
    end
    run(16'h4004, 0, 16'h1234);
    repeat (20) @(posedge clk);
    abort <= 1'b1;
    @(posedge clk);
    abort <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(ctrl[ERROR_BIT], 1'b1)
    `CHK(ctrl[START_BIT], 1'b0)
    end_sim();
  end
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    end_sim();
  end
endmodule // tb_top
